/* File: hw/mdc_consts.vh */
// constants for the master dma channel control block
// assumes an 8-bit i/o port bus synchronous to clk
// How it works
// [RULE_01] status bits 0-3 hold count-done flags of channels 4-7, cleared on status read
// [RULE_02] status bits 5-7 show pending requests of channels 5-7; channel 4 is cascade
// [RULE_03] command register clears on reset and on a master-disable write
// [RULE_04] command bit 7 picks grant polarity: 1 active high, 0 active low
// [RULE_05] command bit 6 picks request polarity: 1 active low, 0 active high
// [RULE_06] command bit 5 picks extended write; ignored while bit 3 is 0
// [RULE_07] command bit 4 picks rotating priority, else fixed priority
// [RULE_08] command bit 3 picks compressed timing; ignored while bit 1 is 0
// [RULE_09] command bit 2 disables the controller; software sets it while programming
// [RULE_10] command bit 1 holds channel 4 address; ignored while bit 0 is 0
// [RULE_11] command bit 0 enables memory-to-memory transfers
// [RULE_12] request port write sets or clears software request of selected channel
// [RULE_13] software sets block mode before relying on a software request
// [RULE_14] mask port write sets or clears selected mask; masked channels ignore requests
// [RULE_15] reset sets all four mask bits
// [RULE_16] each channel keeps 6 mode bits, loaded from bits 7-2 of mode write
// [RULE_17] mode bits 7-6 give service type: demand, single, block, cascade
// [RULE_18] mode bit 5 makes the address step down, else up
// [RULE_19] mode bit 4 enables auto reload
// [RULE_20] mode bits 3-2 give direction kind, ignored in cascade
// [RULE_21] any write to the pointer clear port resets the byte pointer
// [RULE_22] master-disable write acts as hardware reset of the control state; the code does not clear the mode registers or the record fifo on it
// [RULE_23] fixed priority grants lowest channel; rotating makes served channel lowest
`ifndef MDC_CONSTS_VH
`define MDC_CONSTS_VH

`define MDC_PORT_STATCMD 8'hd0
`define MDC_PORT_REQ 8'hd2
`define MDC_PORT_MASK 8'hd4
`define MDC_PORT_MODE 8'hd6
`define MDC_PORT_PTRCLR 8'hd8
`define MDC_PORT_TEMP 8'hda
`define MDC_PORT_CLRMASK 8'hdc
`define MDC_PORT_WRMASK 8'hde
`define MDC_PORT_CHAN_LO 8'hc0
`define MDC_PORT_CHAN_HI 8'hce

`define MDC_CMD_GRANT_POL 7
`define MDC_CMD_REQ_POL 6
`define MDC_CMD_WSTRETCH 5
`define MDC_CMD_ROTATE 4
`define MDC_CMD_COMPRESS 3
`define MDC_CMD_OFF 2
`define MDC_CMD_HOLD 1
`define MDC_CMD_MEMCOPY 0

`define MDC_SEL_SET 2
`define MDC_SEL_HI 1
`define MDC_SEL_LO 0
`define MDC_MODE_HI 7
`define MDC_MODE_LO 2
`define MDC_MODE_W 6

`define MDC_SVC_DEMAND 2'h0
`define MDC_SVC_SINGLE 2'h1
`define MDC_SVC_BLOCK 2'h2
`define MDC_SVC_CASCADE 2'h3

`define MDC_CMD_RESET 8'h00
`define MDC_MASK_RESET 4'hf
`define MDC_REC_W 8
`define MDC_FIFO_DEPTH 32

`endif

/* File: hw/mdc_ctrl.v */
// control, status and arbitration for dma channels 4 to 7
// assumes an 8-bit i/o bus and a transfer datapath outside that
// produces grant records and takes end of service and count done as inputs
`timescale 1ns/1ps
`include "mdc_consts.vh"
module mdc_ctrl #(
  parameter NCH = 4,
  parameter FIFO_DEPTH = `MDC_FIFO_DEPTH,
  parameter FIFO_AW = 5
) (
  input wire clk,
  input wire nrst,
  input wire [7:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  input wire [NCH-1:0] request_line,
  output wire [NCH-1:0] grant_line,
  input wire [NCH-1:0] count_done,
  input wire xfer_done,
  input wire temp_load,
  input wire [7:0] temp_data,
  output wire rec_valid,
  input wire rec_ready,
  output wire [`MDC_REC_W-1:0] rec_data,
  output reg write_stretch,
  output reg compressed_cycles,
  output reg hold_addr_ch_four,
  output reg mem_copy_enable,
  output reg controller_off,
  output reg byte_pointer
);
  localparam ST_IDLE = 2'h0;
  localparam ST_PUSH = 2'h1;
  localparam ST_SERVE = 2'h2;

  reg [7:0] cmd_q;
  reg [NCH-1:0] mask_q;
  reg [NCH-1:0] swreq_q;
  reg [NCH-1:0] done_q;
  reg [`MDC_MODE_W-1:0] mode_q [0:NCH-1];
  reg [7:0] temp_q;
  reg ptr_q;
  reg [1:0] st_q;
  reg [1:0] chan_q;
  reg [1:0] base_q;
  reg [1:0] win_d;
  reg win_found;
  reg [NCH-1:0] served_q;

  wire wr_statcmd = io_wr && (io_addr == `MDC_PORT_STATCMD);
  wire wr_req = io_wr && (io_addr == `MDC_PORT_REQ);
  wire wr_mask = io_wr && (io_addr == `MDC_PORT_MASK);
  wire wr_mode = io_wr && (io_addr == `MDC_PORT_MODE);
  wire wr_ptrclr = io_wr && (io_addr == `MDC_PORT_PTRCLR);
  wire wr_mdis = io_wr && (io_addr == `MDC_PORT_TEMP);
  wire wr_clrmask = io_wr && (io_addr == `MDC_PORT_CLRMASK);
  wire wr_wrmask = io_wr && (io_addr == `MDC_PORT_WRMASK);
  wire rd_stat = io_rd && (io_addr == `MDC_PORT_STATCMD);
  // paired-byte ports of the channel address and count registers
  wire chan_acc = (io_wr || io_rd) && !io_addr[0] &&
                  (io_addr >= `MDC_PORT_CHAN_LO) &&
                  (io_addr <= `MDC_PORT_CHAN_HI);
  wire [1:0] sel = io_wdata[`MDC_SEL_HI:`MDC_SEL_LO];
  wire fifo_ready;
  wire [NCH-1:0] hw_req;
  wire [NCH-1:0] pend;
  wire [NCH-1:0] elig;
  wire [NCH-1:0] grant_act;
  wire [`MDC_MODE_W-1:0] cur_mode;
  wire [1:0] cur_dir;

  // [RULE_05] request sense polarity
  assign hw_req = request_line ^ {NCH{cmd_q[`MDC_CMD_REQ_POL]}};
  assign pend = hw_req | swreq_q;
  // [RULE_14] masked channels ignore requests
  assign elig = pend & ~mask_q & ~served_q;

  // [RULE_23] search from base, lowest index wins
  always @* begin : arb
    integer k;
    reg [1:0] idx;
    win_d = 2'h0;
    win_found = 1'b0;
    idx = 2'h0;
    for (k = NCH - 1; k >= 0; k = k - 1) begin
      idx = base_q + k[1:0];
      if (elig[idx]) begin
        win_d = idx;
        win_found = 1'b1;
      end
    end
  end

  // [RULE_09] no new service starts from idle while the controller is off
  wire start = (st_q == ST_IDLE) && win_found && !cmd_q[`MDC_CMD_OFF];

  always @(posedge clk) begin
    if (!nrst || wr_mdis) begin
      st_q <= ST_IDLE;
      chan_q <= 2'h0;
      base_q <= 2'h0;
      served_q <= {NCH{1'b0}};
    end else begin
      case (st_q)
        ST_IDLE: begin
          served_q <= {NCH{1'b0}};
          if (start) begin
            chan_q <= win_d;
            st_q <= ST_PUSH;
          end
        end
        // stalls here until the fifo has room
        ST_PUSH: begin
          if (fifo_ready) begin
            st_q <= ST_SERVE;
          end
        end
        ST_SERVE: begin
          if (xfer_done) begin
            st_q <= ST_IDLE;
            // [RULE_07] rotate: served channel drops to lowest
            if (cmd_q[`MDC_CMD_ROTATE]) begin
              base_q <= chan_q + 2'h1;
            end else begin
              base_q <= 2'h0;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // [RULE_04] grant polarity
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gl
      assign grant_act[g] = (st_q == ST_SERVE) && (chan_q == g);
      assign grant_line[g] = grant_act[g] ~^ cmd_q[`MDC_CMD_GRANT_POL];
    end
  endgenerate

  // [RULE_17] service type decode
  // [RULE_20] direction kind ignored in cascade
  assign cur_mode = mode_q[chan_q];
  assign cur_dir = (cur_mode[5:4] == `MDC_SVC_CASCADE) ? 2'h0 :
                   cur_mode[1:0];

  // [RULE_18] step direction in record
  // [RULE_19] auto reload in record
  mdc_fifo #(
    .WIDTH(`MDC_REC_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(st_q == ST_PUSH),
    .in_ready(fifo_ready),
    .in_data({chan_q, cur_mode[5:2], cur_dir}),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data(rec_data)
  );

  // [RULE_03] command clears on reset and master disable
  always @(posedge clk) begin
    if (!nrst || wr_mdis) begin
      cmd_q <= `MDC_CMD_RESET;
    end else if (wr_statcmd) begin
      cmd_q <= io_wdata;
    end
  end

  // [RULE_15] reset masks every channel
  // [RULE_22] master disable masks as well
  always @(posedge clk) begin
    if (!nrst || wr_mdis) begin
      mask_q <= `MDC_MASK_RESET;
    end else if (wr_mask) begin
      // [RULE_14] single-channel mask set or clear
      mask_q[sel] <= io_wdata[`MDC_SEL_SET];
    end else if (wr_clrmask) begin
      mask_q <= {NCH{1'b0}};
    end else if (wr_wrmask) begin
      mask_q <= io_wdata[NCH-1:0];
    end
  end

  // software request ends with the channel's count done
  always @(posedge clk) begin
    if (!nrst || wr_mdis) begin
      swreq_q <= {NCH{1'b0}};
    end else begin
      // [RULE_12] software request set or clear
      swreq_q <= (swreq_q & ~count_done) |
                 ((wr_req && io_wdata[`MDC_SEL_SET]) ?
                  ({{(NCH-1){1'b0}}, 1'b1} << sel) : {NCH{1'b0}});
      if (wr_req && !io_wdata[`MDC_SEL_SET]) begin
        swreq_q[sel] <= 1'b0;
      end
    end
  end

  // [RULE_01] count-done flags; a new event beats the read clear
  always @(posedge clk) begin
    if (!nrst || wr_mdis) begin
      done_q <= {NCH{1'b0}};
    end else if (rd_stat) begin
      done_q <= count_done;
    end else begin
      done_q <= done_q | count_done;
    end
  end

  // [RULE_16] per-channel mode store
  genvar m;
  generate
    for (m = 0; m < NCH; m = m + 1) begin : gm
      always @(posedge clk) begin
        if (!nrst) begin
          mode_q[m] <= {`MDC_MODE_W{1'b0}};
        end else if (wr_mode && (sel == m)) begin
          mode_q[m] <= io_wdata[`MDC_MODE_HI:`MDC_MODE_LO];
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (!nrst || wr_mdis) begin
      temp_q <= 8'h00;
    end else if (temp_load) begin
      temp_q <= temp_data;
    end
  end

  // [RULE_21] pointer clear; paired-byte accesses flip it
  always @(posedge clk) begin
    if (!nrst || wr_mdis || wr_ptrclr) begin
      ptr_q <= 1'b0;
    end else if (chan_acc) begin
      ptr_q <= ~ptr_q;
    end
  end

  // read data registered one cycle after the strobe
  always @(posedge clk) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
    end else if (rd_stat) begin
      // [RULE_02] pending flags 5-7, bit 4 held at zero for cascade
      io_rdata <= {pend[3:1], 1'b0, done_q};
    end else if (io_rd && (io_addr == `MDC_PORT_TEMP)) begin
      io_rdata <= temp_q;
    end else if (io_rd) begin
      io_rdata <= 8'h00;
    end
  end

  // option outputs with their don't-care conditions folded in
  always @(posedge clk) begin
    if (!nrst) begin
      write_stretch <= 1'b0;
      compressed_cycles <= 1'b0;
      hold_addr_ch_four <= 1'b0;
      mem_copy_enable <= 1'b0;
      controller_off <= 1'b0;
      byte_pointer <= 1'b0;
    end else begin
      // [RULE_06] extended write needs compressed timing bit
      write_stretch <= cmd_q[`MDC_CMD_WSTRETCH] & cmd_q[`MDC_CMD_COMPRESS];
      // [RULE_08] compressed timing needs hold bit
      compressed_cycles <= cmd_q[`MDC_CMD_COMPRESS] & cmd_q[`MDC_CMD_HOLD];
      // [RULE_10] address hold needs memory copy
      hold_addr_ch_four <= cmd_q[`MDC_CMD_HOLD] & cmd_q[`MDC_CMD_MEMCOPY];
      // [RULE_11] memory-to-memory enable
      mem_copy_enable <= cmd_q[`MDC_CMD_MEMCOPY];
      controller_off <= cmd_q[`MDC_CMD_OFF];
      byte_pointer <= ptr_q;
    end
  end
endmodule

/* File: hw/mdc_fifo.v */
// synchronous fifo carrying grant records to the transfer datapath
// assumes one clock; in and out both use valid/ready
`timescale 1ns/1ps
module mdc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire nrst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

/* File: verif/master_dma_channel_control_test.sv */
// self-checking bench for the dma channel control block
// assumes the design, checker and peripheral model compiled before
`timescale 1ns/1ps
module master_dma_channel_control_test;
  logic clk = 1'b0, nrst = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic temp_load = 1'b0, rec_ready = 1'b1, req_lo = 1'b0;
  logic ack_hi = 1'b0, slow = 1'b0, xfer_done;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, temp_data = 8'h00, d, m;
  logic [3:0] want = 4'h0, request_line, grant_line, count_done, ga;
  wire [7:0] io_rdata, rec_data;
  wire rec_valid, byte_pointer;
  int n_fail = 0, n_checks = 0, nx = 0, np = 0, i, j;
  always #5 clk = ~clk;
  assign ga = ack_hi ? grant_line : ~grant_line;
  mdc_ctrl i_mdc_ctrl (.clk, .nrst, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata, .request_line, .grant_line, .count_done, .xfer_done,
    .temp_load, .temp_data, .rec_valid, .rec_ready, .rec_data,
    .write_stretch(), .compressed_cycles(), .hold_addr_ch_four(),
    .mem_copy_enable(), .controller_off(), .byte_pointer);
  mdc_periph i_mdc_periph (.clk, .nrst, .want, .req_lo, .ack_hi, .slow,
    .grant_line, .request_line, .xfer_done, .count_done);
  always @(posedge clk) begin
    if (xfer_done)
      nx <= nx + 1;
    if (rec_valid && rec_ready)
      np <= np + 1;
  end
  task chk(input [7:0] got, input [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    io_addr <= a;
    io_wdata <= v;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input [7:0] a);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    @(posedge clk);
    #1 d = io_rdata;
  endtask
  task wg(input [3:0] e);
    d = 8'h00;
    for (i = 0; i < 60 && d == 8'h00; i++) begin
      @(posedge clk);
      #1 d = {4'h0, ga};
    end
    chk(d, {4'h0, e});
  endtask
  function [7:0] er(input [1:0] c, input [7:0] v);
    er = {c, v[7:4], v[7:6] == 2'h3 ? 2'h0 : v[3:2]};
  endfunction
  task stop_test;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test;
  end
  initial begin
    d = 8'($urandom(32'h8eefab98));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    want <= 4'hf;
    repeat (10) @(posedge clk);
    chk(grant_line, 8'h0f);
    rd(8'hd0);
    chk(d[7:4], 4'he);
    want <= 4'h0;
    for (int c = 0; c < 4; c++) begin
      m = 8'(($urandom & 8'h3c) | (c << 6));
      wr(8'hd6, m | 8'(c));
      wr(8'hd4, 8'(c));
      want <= 4'h1 << c;
      wg(4'h1 << c);
      chk(rec_data, er(2'(c), m));
      want <= 4'h0;
      repeat (12) @(posedge clk);
      wr(8'hd4, 8'(c + 4));
      rd(8'hd0);
      chk(d[3:0], 4'h1 << c);
      rd(8'hd0);
      chk(d[3:0], 4'h0);
    end
    wr(8'hd6, 8'h82);
    wr(8'hd2, 8'h06);
    rd(8'hd0);
    chk(d[6], 1'b1);
    wr(8'hd2, 8'h02);
    rd(8'hd0);
    chk(d[6], 1'b0);
    wr(8'hd2, 8'h06);
    wr(8'hd4, 8'h02);
    wg(4'h4);
    repeat (12) @(posedge clk);
    rd(8'hd0);
    chk(d[6], 1'b0);
    wr(8'hdc, 8'h00);
    for (int r = 0; r < 2; r++) begin
      wr(8'hd0, 8'(r << 4));
      want <= 4'h2;
      wg(4'h2);
      want <= 4'h0;
      repeat (12) @(posedge clk);
      want <= 4'h9;
      wg(r ? 4'h8 : 4'h1);
      want <= 4'h0;
      repeat (12) @(posedge clk);
    end
    wr(8'hde, 8'h0f);
    wr(8'hd0, 8'hc4);
    req_lo <= 1'b1;
    ack_hi <= 1'b1;
    wr(8'hd4, 8'h02);
    want <= 4'h4;
    repeat (20) @(posedge clk);
    chk(grant_line, 8'h00);
    wr(8'hd0, 8'hc0);
    wg(4'h4);
    chk(grant_line, 8'h04);
    want <= 4'h0;
    repeat (12) @(posedge clk);
    temp_data <= 8'($urandom);
    temp_load <= 1'b1;
    @(posedge clk);
    temp_load <= 1'b0;
    rd(8'hda);
    chk(d, temp_data);
    wr(8'hda, 8'h00);
    req_lo <= 1'b0;
    ack_hi <= 1'b0;
    rd(8'hda);
    chk(d, 8'h00);
    want <= 4'hf;
    repeat (10) @(posedge clk);
    chk(grant_line, 8'h0f);
    want <= 4'h0;
    for (int k = 0; k < 8; k++) begin
      wr(8'hd0, 8'($urandom));
      rd(8'hc0 + 8'($urandom & 14));
      rd(8'h55);
      wr(8'hd8, 8'($urandom));
      repeat (2) @(posedge clk);
      #1 chk(byte_pointer, 1'b0);
    end
    wr(8'hda, 8'h00);
    wr(8'hd4, 8'h03);
    slow <= 1'b1;
    rec_ready <= 1'b0;
    // pulses with no grant behind them happen on polarity flips
    i = nx;
    j = np;
    want <= 4'h8;
    repeat (600) @(posedge clk);
    chk(8'(nx - i), 8'h20);
    want <= 4'h0;
    rec_ready <= 1'b1;
    repeat (100) @(posedge clk);
    chk(8'((np - j) - (nx - i)), 8'h00);
    chk(rec_valid, 1'b0);
    stop_test;
  end
endmodule

/* File: verif/mdc_ctrl_properties.sv */
// port checks for the dma channel control block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module mdc_ctrl_props #(
  parameter NCH = 4
) (
  input wire clk,
  input wire nrst,
  input wire [7:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire [NCH-1:0] grant_line,
  input wire [NCH-1:0] count_done,
  input wire xfer_done,
  input wire write_stretch,
  input wire compressed_cycles,
  input wire hold_addr_ch_four,
  input wire mem_copy_enable,
  input wire controller_off,
  input wire byte_pointer
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  reg [7:0] cmd_q;
  reg [NCH-1:0] tc_q;
  wire wcmd = io_wr && io_addr == 8'hd0;
  wire wdis = io_wr && io_addr == 8'hda;
  wire rdst = io_rd && io_addr == 8'hd0;
  wire chacc = (io_wr || io_rd) && io_addr[7:4] == 4'hc && !io_addr[0];
  wire [NCH-1:0] ga = cmd_q[7] ? grant_line : ~grant_line;
  always @(posedge clk) begin
    if (!nrst || wdis) begin
      cmd_q <= 8'h00;
      tc_q <= '0;
    end else begin
      if (wcmd)
        cmd_q <= io_wdata;
      tc_q <= (rdst ? '0 : tc_q) | count_done;
    end
  end
  rst_idle_a: assert property (disable iff (1'b0)
    !nrst |=> io_rdata == 8'h00 && grant_line == '1 && !byte_pointer)
    else $error("state after reset wrong");
  opt_timing_a: assert property ($stable(cmd_q) |->
    write_stretch == (cmd_q[5] && cmd_q[3]) &&
    compressed_cycles == (cmd_q[3] && cmd_q[1])) else $error("timing opts");
  opt_hold_a: assert property ($stable(cmd_q) |->
    hold_addr_ch_four == (cmd_q[1] && cmd_q[0]) &&
    mem_copy_enable == cmd_q[0]) else $error("hold or copy option");
  ctl_off_a: assert property ($stable(cmd_q) |->
    controller_off == cmd_q[2]) else $error("controller off level");
  ptr_clear_a: assert property (
    io_wr && io_addr == 8'hd8 ##1 !chacc |=> !byte_pointer)
    else $error("byte pointer not cleared");
  mdis_idle_a: assert property (wdis |=> grant_line == '1)
    else $error("grant after master disable");
  stat_rsvd_a: assert property (rdst |=> io_rdata[4] == 1'b0)
    else $error("status bit 4 set");
  tc_flags_a: assert property (
    rdst |=> io_rdata[NCH-1:0] == $past(tc_q)) else $error("count flags");
  grant_keep_a: assert property (
    ga != '0 && !xfer_done && !wcmd && !wdis |=> $stable(grant_line))
    else $error("grant dropped early");
  grant_end_a: assert property (
    ga != '0 && xfer_done && !wcmd |=> ga == '0) else $error("grant kept");
endmodule
bind mdc_ctrl mdc_ctrl_props #(.NCH(NCH)) i_mdc_ctrl_props (.clk, .nrst,
  .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .grant_line,
  .count_done, .xfer_done, .write_stretch, .compressed_cycles,
  .hold_addr_ch_four, .mem_copy_enable, .controller_off, .byte_pointer);

/* File: verif/mdc_periph.sv */
// peripherals and datapath: request pins and end-of-service pulses
// assumes the bench passes on the polarity bits it commanded
`timescale 1ns/1ps
module mdc_periph (
  input wire clk,
  input wire nrst,
  input wire [3:0] want,
  input wire req_lo,
  input wire ack_hi,
  input wire slow,
  input wire [3:0] grant_line,
  output wire [3:0] request_line,
  output logic xfer_done = 1'b0,
  output logic [3:0] count_done = 4'h0
);
  logic [3:0] ga;
  logic [2:0] n = 3'h0;
  assign request_line = req_lo ? ~want : want;
  assign ga = ack_hi ? grant_line : ~grant_line;
  // slow mode stalls each service
  always @(posedge clk) begin
    xfer_done <= 1'b0;
    count_done <= 4'h0;
    if (!nrst || ga == 4'h0 || xfer_done)
      n <= 3'h0;
    else if (n == (slow ? 3'h4 : 3'h0)) begin
      xfer_done <= 1'b1;
      count_done <= ga;
    end else
      n <= n + 3'h1;
  end
endmodule
